// >>> rtl/pll_counter_divider_chain.sv
// counter chain of a phase-locked loop: pre-scale, feedback and five post-scale dividers
// assumes clock is the oscillator clock, refClockIn and loopResetReq are asynchronous pins
//
// What this block does
// - feedback mode selectable among four; every mode keeps all divider features.
// - one pre-scale and one feedback divider, each ratio 1 through 512.
// - pre-scale divider only divides frequency; no high/low duty control.
// - output rate is input times feedback over pre-scale times post-scale.
// - five independent post-scale dividers feed global net or external pin.
// - each output has its own divider of the shared oscillator clock.
// - post-scale ratio 1 through 512 allowed at fifty percent duty.
// - non-fifty-percent duty limits post-scale ratio to 1 through 256.
// - post-scale ratio equals high count plus low count.
// - cascading feeds one divider output into the next for larger ratios.
// - cascaded dividers act as one divider with the product ratio.
// - cascading fixed by configuration image; run-time writes cannot change it.
// - only the first output divider may drive the external clock pin.
// - active-high loop reset from core resets and resynchronizes all dividers.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pll_chain_defs.svh"

module pll_counter_divider_chain
  import pll_chain_pkg::*;
#(
  parameter logic [4:0] CASCADE_MASK = 5'h00  // image setting, bit i chains divider i to i-1
)
(
  input  wire logic        clock,           // oscillator clock, 200 MHz
  input  wire logic        rst,             // sync reset, high
  input  wire logic        refClockIn,      // reference clock pin
  input  wire logic        loopResetReq,    // loop reset from core, high
  input  wire logic        hsel,            // ahb select
  input  wire logic [31:0] haddr,           // ahb address
  input  wire logic [1:0]  htrans,          // ahb transfer type
  input  wire logic        hwrite,          // ahb write
  input  wire logic [2:0]  hsize,           // ahb size
  input  wire logic [31:0] hwdata,          // ahb write data
  input  wire logic        hready,          // ahb bus ready
  output logic             hreadyout,       // ahb slave ready
  output logic             hresp,           // ahb response
  output logic [31:0]      hrdata,          // ahb read data
  output logic [4:0]       globalClockNet,  // divider outputs to clock net
  output logic             extClockOut,     // external clock pin
  output logic             extClockOe,      // external pin enable
  output fb_mode_t         feedbackMode,    // selected feedback mode
  output logic             refTickOut,      // phase detector reference tick
  output logic             fbTickOut        // phase detector feedback tick
);

  localparam int NUM_OUT = 5;

  // ****************************************
  // state and nets
  // ****************************************
  chain_state_t sReg;
  chain_state_t sNext;
  logic         loopReset;
  logic [4:0]   divTick;
  logic [4:0]   divAdvance;

  // ****************************************
  // legality checks
  // ****************************************
  function automatic logic ratio_ok(input logic [9:0] r);
    return (r != 10'h000) && (r <= `RATIO_MAX);
  endfunction

  // ****************************************
  // post-scale setting legality
  // ****************************************
  function automatic logic cfg_ok(input div_cfg_t c);
    logic [9:0] total;
    logic       even;
    total = {1'b0, c.high} + {1'b0, c.low};
    even  = (c.high == c.low) || (c.high == c.low + 9'h001) || (c.low == c.high + 9'h001);
    if ((c.high == 9'h000) || (c.high > `COUNT_MAX) || (c.low > `COUNT_MAX))
    begin
      return 1'b0;
    end
    if ((c.low == 9'h000) && (c.high != 9'h001))
    begin
      return 1'b0;
    end
    if (even)
    begin
      return total <= `RATIO_MAX;
    end
    return total <= `SKEW_RATIO_MAX;
  endfunction

  // ****************************************
  // state update and register bus
  // ****************************************
  always_comb
  begin
    sNext         = sReg;
    sNext.refTick = 1'b0;
    sNext.fbTick  = 1'b0;

    // ****************************************
    // pin synchronisers
    // ****************************************
    sNext.refSync       = {sReg.refSync[0], refClockIn};
    sNext.loopResetSync = {sReg.loopResetSync[0], loopResetReq};
    sNext.refPrev       = sReg.refSync[1];

    // ****************************************
    // reference pre-scale divider
    // ****************************************
    // pre-scale counts reference edges only
    if (sReg.refSync[1] && !sReg.refPrev)
    begin
      if (sReg.preCount + 10'h001 >= sReg.preRatio)
      begin
        sNext.preCount = 10'h000;
        sNext.refTick  = 1'b1;
      end
      else
      begin
        sNext.preCount = sReg.preCount + 10'h001;
      end
    end

    // ****************************************
    // feedback divider
    // ****************************************
    // feedback divides oscillator by m
    if (sReg.fbCount + 10'h001 >= sReg.fbRatio)
    begin
      sNext.fbCount = 10'h000;
      sNext.fbTick  = 1'b1;
    end
    else
    begin
      sNext.fbCount = sReg.fbCount + 10'h001;
    end

    // ****************************************
    // phase comparison
    // ****************************************
    if (sReg.refTick && !sReg.fbTick && (sReg.phaseDiff != 8'sh7f))
    begin
      sNext.phaseDiff = sReg.phaseDiff + 8'sh01;
    end
    else if (sReg.fbTick && !sReg.refTick && (sReg.phaseDiff != -8'sh80))
    begin
      sNext.phaseDiff = sReg.phaseDiff - 8'sh01;
    end

    // ****************************************
    // loop reset of counters
    // ****************************************
    // loop reset clears counters
    if (loopReset)
    begin
      sNext.preCount  = 10'h000;
      sNext.fbCount   = 10'h000;
      sNext.refTick   = 1'b0;
      sNext.fbTick    = 1'b0;
      sNext.phaseDiff = 8'sh00;
    end

    // ****************************************
    // register writes in the data phase
    // ****************************************
    if (sReg.dpWrite)
    begin
      case (sReg.dpAddr)
        `OFS_CTRL:
        begin
          sNext.mode      = fb_mode_t'(hwdata[`CTRL_MODE_LSB +: 2]);
          sNext.extEnable = hwdata[`CTRL_EXT_BIT];
          sNext.softReset = hwdata[`CTRL_SRST_BIT];
          sNext.rejected  = 1'b0;
        end
        `OFS_PRE_RATIO:
        begin
          sNext.rejected = !ratio_ok(hwdata[9:0]) || (hwdata[31:10] != 22'h000000);
          if (!sNext.rejected)
          begin
            sNext.preRatio = hwdata[9:0];
          end
        end
        `OFS_FB_RATIO:
        begin
          sNext.rejected = !ratio_ok(hwdata[9:0]) || (hwdata[31:10] != 22'h000000);
          if (!sNext.rejected)
          begin
            sNext.fbRatio = hwdata[9:0];
          end
        end
        default:
        begin
          for (int i = 0; i < NUM_OUT; i++)
          begin
            if (sReg.dpAddr == `OFS_OUT0 + 8'(i) * `OFS_OUT_STEP)
            begin
              sNext.rejected = !cfg_ok({hwdata[`OUT_HIGH_LSB +: 9], hwdata[`OUT_LOW_LSB +: 9]});
              if (!sNext.rejected)
              begin
                sNext.outCfg[i] = {hwdata[`OUT_HIGH_LSB +: 9], hwdata[`OUT_LOW_LSB +: 9]};
              end
            end
          end
        end
      endcase
    end

    // ****************************************
    // address phase and read data
    // ****************************************
    sNext.dpWrite = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      sNext.dpWrite = hwrite;
      sNext.dpAddr  = haddr[7:0];
      sNext.rdata   = 32'h00000000;
      if (!hwrite)
      begin
        case (haddr[7:0])
          `OFS_CTRL:
          begin
            sNext.rdata[`CTRL_MODE_LSB +: 2] = sNext.mode;
            sNext.rdata[`CTRL_EXT_BIT]       = sNext.extEnable;
            sNext.rdata[`CTRL_SRST_BIT]      = sNext.softReset;
          end
          `OFS_PRE_RATIO:
          begin
            sNext.rdata[9:0] = sNext.preRatio;
          end
          `OFS_FB_RATIO:
          begin
            sNext.rdata[9:0] = sNext.fbRatio;
          end
          `OFS_STATUS:
          begin
            sNext.rdata[`ST_OUT_LSB +: 5]   = globalClockNet;
            sNext.rdata[`ST_CASC_LSB +: 5]  = CASCADE_MASK;
            sNext.rdata[`ST_REJ_BIT]        = sNext.rejected;
            sNext.rdata[`ST_PHASE_LSB +: 8] = sNext.phaseDiff;
          end
          default:
          begin
            for (int i = 0; i < NUM_OUT; i++)
            begin
              if (haddr[7:0] == `OFS_OUT0 + 8'(i) * `OFS_OUT_STEP)
              begin
                sNext.rdata[`OUT_HIGH_LSB +: 9] = sNext.outCfg[i].high;
                sNext.rdata[`OUT_LOW_LSB +: 9]  = sNext.outCfg[i].low;
              end
            end
          end
        endcase
      end
    end

    // ****************************************
    // synchronous reset
    // ****************************************
    if (rst)
    begin
      // reference synchroniser keeps sampling so a high pin gives no false edge
      sNext.loopResetSync = 2'h0;
      sNext.preCount      = 10'h000;
      sNext.fbCount       = 10'h000;
      sNext.refTick       = 1'b0;
      sNext.fbTick        = 1'b0;
      sNext.phaseDiff     = 8'sh00;
      sNext.mode          = MODE_NORMAL;
      sNext.extEnable     = 1'b0;
      sNext.softReset     = 1'b0;
      sNext.preRatio      = `RST_RATIO;
      sNext.fbRatio       = `RST_RATIO;
      sNext.outCfg        = {NUM_OUT{`RST_HIGH, `RST_LOW}};
      sNext.rejected      = 1'b0;
      sNext.dpWrite       = 1'b0;
      sNext.dpAddr        = 8'h00;
      sNext.rdata         = 32'h00000000;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock)
  begin
    sReg <= sNext;
  end

  // ****************************************
  // loop reset
  // ****************************************
  // pin, soft bit or bus reset
  assign loopReset = rst || sReg.loopResetSync[1] || sReg.softReset;

  // ****************************************
  // post-scale dividers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : gen_out
      if (g == 0)
      begin : gen_first
        assign divAdvance[g] = 1'b1;
      end
      else
      begin : gen_next
        assign divAdvance[g] = CASCADE_MASK[g] ? divTick[g-1] : 1'b1;
      end

      post_scale_divider post_scale_divider_inst (
        .clock      (clock),
        .rst        (loopReset),
        .advance    (divAdvance[g]),
        .cfg        (sReg.outCfg[g]),
        .clkOut     (globalClockNet[g]),
        .periodTick (divTick[g])
      );
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  // first divider only to pin
  assign extClockOut  = globalClockNet[0] && sReg.extEnable;
  assign extClockOe   = sReg.extEnable;
  assign feedbackMode = sReg.mode;
  assign refTickOut   = sReg.refTick;
  assign fbTickOut    = sReg.fbTick;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = sReg.rdata;

endmodule // pll_counter_divider_chain

`default_nettype wire

// >>> rtl/pll_chain_defs.svh
// register offsets, field positions, reset values and limits of the pll counter chain
// assumes byte addressing on a 32-bit ahb-lite bus, one word per register
`ifndef PLL_CHAIN_DEFS_SVH
`define PLL_CHAIN_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_PRE_RATIO   8'h04
`define OFS_FB_RATIO    8'h08
`define OFS_OUT0        8'h0c
`define OFS_OUT_STEP    8'h04
`define OFS_STATUS      8'h20

// ****************************************
// field positions
// ****************************************
`define CTRL_MODE_LSB   0
`define CTRL_EXT_BIT    2
`define CTRL_SRST_BIT   3
`define OUT_HIGH_LSB    0
`define OUT_LOW_LSB     16
`define ST_OUT_LSB      0
`define ST_CASC_LSB     5
`define ST_REJ_BIT      10
`define ST_PHASE_LSB    16

// ****************************************
// reset values and limits
// ****************************************
`define RST_RATIO       10'h001
`define RST_HIGH        9'h001
`define RST_LOW         9'h001
`define RATIO_MAX       10'h200
`define SKEW_RATIO_MAX  10'h100
`define COUNT_MAX       9'h100

`endif

// >>> rtl/pll_chain_pkg.sv
// types shared by the pll counter chain and its post-scale dividers
// assumes nothing of its surroundings
`default_nettype none

package pll_chain_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL       = 2'h0,
    MODE_SOURCE_SYNC  = 2'h1,
    MODE_NO_COMP      = 2'h2,
    MODE_PIN_ALIGNED  = 2'h3
  } fb_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_HIGH = 2'h1,
    PH_LOW  = 2'h3
  } div_phase_t;

  typedef struct packed {
    logic [8:0] high;
    logic [8:0] low;
  } div_cfg_t;

  typedef struct packed {
    div_phase_t phase;
    logic [8:0] count;
  } div_state_t;

  typedef struct packed {
    logic [1:0]        refSync;
    logic              refPrev;
    logic [1:0]        loopResetSync;
    logic [9:0]        preCount;
    logic [9:0]        fbCount;
    logic              refTick;
    logic              fbTick;
    logic signed [7:0] phaseDiff;
    fb_mode_t          mode;
    logic              extEnable;
    logic              softReset;
    logic [9:0]        preRatio;
    logic [9:0]        fbRatio;
    div_cfg_t [4:0]    outCfg;
    logic              rejected;
    logic              dpWrite;
    logic [7:0]        dpAddr;
    logic [31:0]       rdata;
  } chain_state_t;

endpackage

`default_nettype wire

// >>> rtl/post_scale_divider.sv
// one post-scale output divider: high count then low count of advance pulses
// assumes advance is a one-cycle enable on the oscillator clock
`timescale 1ns/1ps
`default_nettype none

module post_scale_divider
  import pll_chain_pkg::*;
(
  input  wire logic     clock,      // oscillator clock
  input  wire logic     rst,        // loop reset, sync, high
  input  wire logic     advance,    // count enable
  input  wire div_cfg_t cfg,        // high and low counts
  output logic          clkOut,     // divided clock
  output logic          periodTick  // last advance of a period
);

  div_state_t sReg;
  div_state_t sNext;

  // ****************************************
  // high then low phase counter
  // ****************************************
  always_comb
  begin
    sNext      = sReg;
    periodTick = 1'b0;
    case (sReg.phase)
      PH_IDLE:
      begin
        if (advance)
        begin
          sNext.phase = PH_HIGH;
          sNext.count = 9'h001;
        end
      end
      PH_HIGH:
      begin
        if (advance)
        begin
          if (sReg.count >= cfg.high)
          begin
            sNext.count = 9'h001;
            if (cfg.low == 9'h000)
            begin
              periodTick = 1'b1;
            end
            else
            begin
              sNext.phase = PH_LOW;
            end
          end
          else
          begin
            sNext.count = sReg.count + 9'h001;
          end
        end
      end
      PH_LOW:
      begin
        if (advance)
        begin
          if (sReg.count >= cfg.low)
          begin
            periodTick  = 1'b1;
            sNext.phase = PH_HIGH;
            sNext.count = 9'h001;
          end
          else
          begin
            sNext.count = sReg.count + 9'h001;
          end
        end
      end
      default:
      begin
        sNext.phase = PH_IDLE;
        sNext.count = 9'h000;
      end
    endcase
    if (rst)
    begin
      sNext.phase = PH_IDLE;
      sNext.count = 9'h000;
      periodTick  = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    sReg <= sNext;
  end

  assign clkOut = (sReg.phase == PH_HIGH);

endmodule // post_scale_divider

`default_nettype wire

// >>> testbench/chain_chk.sv
// port checker of the pll counter chain
// assumes a bind onto the chain top, one clock domain
`timescale 1ns/1ps
`default_nettype none

module chain_chk
  import pll_chain_pkg::*;
#(
  parameter logic [4:0] CASCADE_MASK = 5'h00  // image cascade
)
(
  input wire logic        clock,           // clock
  input wire logic        rst,             // reset
  input wire logic        loopResetReq,    // loop reset
  input wire logic        hsel,            // select
  input wire logic [31:0] haddr,           // address
  input wire logic [1:0]  htrans,          // transfer
  input wire logic        hwrite,          // write
  input wire logic        hready,          // ready in
  input wire logic [31:0] hrdata,          // read data
  input wire logic [4:0]  globalClockNet,  // outputs
  input wire logic        extClockOut,     // pin
  input wire logic        extClockOe,      // pin enable
  input wire fb_mode_t    feedbackMode     // mode
);
  logic       wrPend_reg;
  logic       rdPend_reg;
  logic [7:0] addr_reg;
  wire logic  ctrlWr = wrPend_reg && addr_reg == 8'h00;

  always_ff @(posedge clock)
  begin
    wrPend_reg <= hsel && htrans[1] && hready && hwrite;
    rdPend_reg <= hsel && htrans[1] && hready && !hwrite;
    if (hsel && htrans[1] && hready)
      addr_reg <= haddr[7:0];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ****************************************
  // properties
  // ****************************************
  sequence sRelease;
    rst ##1 (!rst && !loopResetReq) [*5];
  endsequence

  AST_EXT_PIN: assert property (extClockOut |-> globalClockNet[0] && extClockOe)
    else $error("ext pin high without divider 0");
  AST_EXT_IDLE: assert property (!extClockOe |-> !extClockOut)
    else $error("ext pin driven while disabled");
  AST_LOOP_RST: assert property (loopResetReq [*4] |=> globalClockNet == 5'h00)
    else $error("outputs run during loop reset");
  AST_REL_TOGGLE: assert property (disable iff (1'b0) sRelease |-> globalClockNet[4] != $past(globalClockNet[4]))
    else $error("divider 4 not toggling at ratio 2");
  AST_REL_ALIKE: assert property (disable iff (1'b0) sRelease |-> globalClockNet[1] == globalClockNet[4])
    else $error("like dividers out of step");
  AST_MODE: assert property ($changed(feedbackMode) |-> $past(ctrlWr) || $past(ctrlWr, 2))
    else $error("mode changed without control write");
  AST_OE: assert property ($changed(extClockOe) |-> $past(ctrlWr) || $past(ctrlWr, 2))
    else $error("pin enable changed without control write");
  AST_CASC: assert property (rdPend_reg && addr_reg == 8'h20 |-> hrdata[9:6] == CASCADE_MASK[4:1])
    else $error("cascade status differs from image");
endmodule // chain_chk

`default_nettype wire

// >>> testbench/core_side_model.sv
// core side of the chain: reference clock source and loop reset driver
// assumes a 5 ns core clock
`timescale 1ns/1ps
`default_nettype none

module core_side_model
(
  input  wire logic clock,        // core clock
  output logic      refClockIn,   // reference clock pin
  output logic      loopResetReq  // loop reset request
);
  // 50 ns reference, offset from core edges
  initial
  begin
    refClockIn = 1'b0;
    loopResetReq = 1'b0;
    #1.2;
    forever #25 refClockIn = ~refClockIn;
  end

  task hold_loop_reset(input int n);
    @(posedge clock);
    loopResetReq <= 1'b1;
    repeat (n) @(posedge clock);
    loopResetReq <= 1'b0;
  endtask
endmodule // core_side_model

`default_nettype wire

// >>> testbench/test_pll_counter_divider_chain.sv
// self-checking bench of the pll counter chain
// assumes the chain package, the checker and the core side model
`timescale 1ns/1ps
`default_nettype none

module test_pll_counter_divider_chain;
  localparam logic [4:0] CMASK = 5'h04;
  logic             clock, rst, hsel, hwrite, dataRd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata;
  wire logic        refClockIn, loopResetReq, hready, hreadyout, hresp;
  wire logic        extClockOut, extClockOe, refTickOut, fbTickOut;
  wire logic [31:0] hrdata;
  wire logic [4:0]  globalClockNet;
  wire logic [1:0]  feedbackMode;
  wire logic [1:0]  ticks = {refTickOut, fbTickOut};
  int               error_cnt, cmp_count, seed, h, l;
  logic [63:0]      expQ[$];
  logic [63:0]      e;

  assign hready = hreadyout;

  pll_counter_divider_chain #(.CASCADE_MASK(CMASK)) pll_counter_divider_chain_inst (
    .clock(clock), .rst(rst), .refClockIn(refClockIn), .loopResetReq(loopResetReq),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .globalClockNet(globalClockNet), .extClockOut(extClockOut), .extClockOe(extClockOe),
    .feedbackMode(feedbackMode), .refTickOut(refTickOut), .fbTickOut(fbTickOut));

  core_side_model core_side_model_inst (.clock(clock), .refClockIn(refClockIn), .loopResetReq(loopResetReq));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************************************
  // tasks
  // ****************************************
  task give_verdict;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wt;
    int k;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // one single word transfer; a read queues {mask, expected}
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [63:0] x);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dataRd <= !w;
    if (!w)
      expQ.push_back(x);
    wt();
    dataRd <= 1'b0;
  endtask

  task automatic run(input int i, input logic lv, output int n);
    n = 0;
    while (globalClockNet[i] === lv && n < 3000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask

  task automatic meas(input int i, input int eh, input int el);
    int n;
    @(posedge clock);
    #1;
    run(i, 1'b1, n);
    run(i, 1'b0, n);
    run(i, 1'b1, n);
    check("high time", n, eh);
    run(i, 1'b0, n);
    check("low time", n, el);
  endtask

  task automatic gap(input int b, input int exp);
    int n;
    n = 0;
    while (ticks[b] !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 100)
    begin
      error_cnt++;
      give_verdict();
    end
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (ticks[b] !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      error_cnt++;
      give_verdict();
    end
    check("tick gap", n, exp);
  endtask

  // read data compared in its data phase
  always @(posedge clock)
    if (dataRd)
    begin
      e = expQ.pop_front();
      check("read data", hrdata & e[63:32], e[31:0]);
      check("response", {31'h0, hresp}, 32'h0);
    end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 32'haf4c;
    {rst, hsel, hwrite, dataRd, htrans, haddr, hwdata} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 40; a += 4)
      if (a != 32)
        ahb(1'b0, a[7:0], 0, {32'hffffffff, (a == 0 || a == 36) ? 32'h0 : a < 12 ? 32'h1 : 32'h10001});
    for (int m = 0; m < 4; m++)
    begin
      ahb(1'b1, 8'h00, m, 0);
      ahb(1'b0, 8'h00, 0, {32'hffffffff, m});
      check("mode", {30'h0, feedbackMode}, m);
    end
    ahb(1'b1, 8'h04, 32'h201, 0);
    ahb(1'b0, 8'h04, 0, {32'hffffffff, 32'h1});
    ahb(1'b0, 8'h20, 0, {32'h7e0, 32'h400 | {CMASK, 5'h0}});
    ahb(1'b1, 8'h04, 32'h2, 0);
    ahb(1'b1, 8'h08, 32'h4, 0);
    ahb(1'b1, 8'h10, 32'h00020003, 0);
    ahb(1'b1, 8'h14, 32'h00010002, 0);
    ahb(1'b1, 8'h18, 32'h01000100, 0);
    ahb(1'b1, 8'h1c, 32'h006400c8, 0);
    ahb(1'b0, 8'h1c, 0, {32'hffffffff, 32'h10001});
    h = 1 + {$random(seed)} % 100;
    l = 1 + {$random(seed)} % 100;
    ahb(1'b1, 8'h0c, (l << 16) | h, 0);
    ahb(1'b1, 8'h00, 32'h4, 0);
    repeat (2) @(posedge clock);
    #1;
    check("pin enable", {31'h0, extClockOe}, 1);
    meas(1, 3, 2);
    meas(2, 10, 5);
    meas(3, 256, 256);
    meas(0, h, l);
    meas(4, 1, 1);
    gap(0, 4);
    gap(1, 20);
    fork
      core_side_model_inst.hold_loop_reset(8);
    join_none
    repeat (7) @(posedge clock);
    #1;
    check("outputs in loop reset", {27'h0, globalClockNet}, 0);
    meas(1, 3, 2);
    // soft loop reset bit holds every divider idle
    ahb(1'b1, 8'h00, 32'hc, 0);
    ahb(1'b0, 8'h00, 0, {32'hffffffff, 32'hc});
    #1;
    check("outputs in soft reset", {27'h0, globalClockNet}, 0);
    check("pin in soft reset", {31'h0, extClockOut}, 0);
    ahb(1'b1, 8'h00, 32'h4, 0);
    meas(4, 1, 1);
    give_verdict();
  end
endmodule // test_pll_counter_divider_chain

bind pll_counter_divider_chain chain_chk #(.CASCADE_MASK(CASCADE_MASK)) chain_chk_inst (
  .clock(clock), .rst(rst), .loopResetReq(loopResetReq), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .globalClockNet(globalClockNet), .extClockOut(extClockOut), .extClockOe(extClockOe),
  .feedbackMode(feedbackMode));

`default_nettype wire
